// >>> test/cbs_core_regs_bench.sv
// Self-checking bench for the core bank and status registers
`timescale 1ns/1ps
`include "cbs_map.vh"
`define CBS_CHK(g, e) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  miscompares = miscompares + 1; $display("wrong value at %0t: got %h want %h", $time, g, e); end end
module cbs_core_regs_bench;
  reg clk = 0, nrst = 0, wrst_n = 1, por = 1, wr_en = 0, rd_en = 0, ind = 0, ld = 0, wto = 0;
  reg wclr = 0, halt = 0, trd = 0, tb = 0, fb = 0;
  reg [7:0] addr = 0, wd = 0, a = 0, b = 0;
  reg [2:0] op = 0;
  wire [7:0] rdat, acc, st;
  wire [15:0] tdat, tadr;
  wire [12:0] pc;
  wire [13:0] tgt, pbase;
  wire [2:0] bank;
  wire pld, dum, undef, pbank;
  integer miscompares = 0, total_checks = 0, cyc = 0, i;
  reg [27:0] tab [0:7];
  cbs_core_regs dut (.CLOCK(clk), .NRST(nrst), .WDT_RST_N(wrst_n), .POR_FLAG(por), .WR_EN(wr_en),
    .RD_EN(rd_en), .ADDR(addr), .INDIRECT(ind), .WR_DATA(wd), .RD_DATA(rdat), .ALU_OP(op), .ALU_A(a),
    .ALU_B(b), .ACC_LOAD(ld), .WDT_TIMEOUT(wto), .WATCHDOG_CLEAR_INSTR(wclr), .HALT_INSTR(halt),
    .TABLE_READ(trd), .TABLE_DATA(tdat), .TABLE_ADDR(tadr), .TWO_BIT_BANKS(tb), .FOUR_BANKS(fb),
    .PC_CURRENT(pc), .PC_LOAD(pld), .PC_TARGET(tgt), .DUMMY_CYCLE(dum), .DATA_BANK(bank),
    .DATA_BANK_UNDEF(undef), .PROG_BANK(pbank), .PROG_BASE(pbase), .ACCUMULATOR(acc), .FLAGS_STATUS(st));
  cbs_cpu_model cpu (.clk(clk), .nrst(nrst), .pc_load(pld), .pc_target(tgt), .table_addr(tadr),
    .pc_current(pc), .table_data(tdat));
  initial forever #4 clk = ~clk;
  task close_out;
    begin
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  // Whole run is well under a thousand cycles
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  task step(input integer n); repeat (n) @(posedge clk); endtask
  task wr(input [7:0] ad, input [7:0] d);
    begin
      @(posedge clk) begin addr <= ad; wd <= d; wr_en <= 1'b1; ind <= 1'b0; end
      @(posedge clk) wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] ad, input [7:0] m, input [7:0] e);
    begin
      @(posedge clk) begin addr <= ad; rd_en <= 1'b1; end
      #2 `CBS_CHK(rdat & m, e)
    end
  endtask
  task alu(input [2:0] o, input [7:0] x, input [7:0] y);
    begin
      @(posedge clk) begin op <= o; a <= x; b <= y; ld <= 1'b1; end
      @(posedge clk) begin op <= `CBS_OP_NONE; ld <= 1'b0; end
    end
  endtask
  task wdt_reset;
    begin
      @(posedge clk) wrst_n <= 1'b0;
      step(4);
      wrst_n <= 1'b1;
      step(3);
    end
  endtask
  initial begin
    // {op, a, b, flag mask, flags} with flags as {ov, z, ac, c}
    tab[0] = 28'h17f01fa; tab[1] = 28'h1ff01f7; tab[2] = 28'h20505f7; tab[3] = 28'h20001f0;
    tab[4] = 28'h3000044; tab[5] = 28'h3005a40; tab[6] = 28'h4808011; tab[7] = 28'h5020210;
    step(3);
    nrst <= 1'b1;
    step(2);
    por <= 1'b0;
    rd(`CBS_ADDR_BANK_SELECT, 8'hff, 8'h00);
    rd(`CBS_ADDR_FLAGS_STATUS, 8'hf0, 8'h00);
    wr(`CBS_ADDR_BANK_SELECT, 8'hff);
    rd(`CBS_ADDR_BANK_SELECT, 8'hff, 8'h27);
    `CBS_CHK({pbank, pbase}, {1'b1, `CBS_PROG_BANK1_LO})
    for (i = 0; i < 24; i = i + 1) if (i < 8 || i % 8 < 4) begin
      wr(`CBS_ADDR_BANK_SELECT, i % 8);
      @(posedge clk) begin ind <= 1'b1; tb <= i >= 8; fb <= i >= 16; end
      #2 `CBS_CHK(bank, i[2:0])
      `CBS_CHK(undef, i < 8 ? i > 5 : (i % 8 == 3 && i < 16))
    end
    wr(`CBS_ADDR_BANK_SELECT, 8'h05);
    wr(`CBS_ADDR_ACCUMULATOR, 8'h5e);
    rd(`CBS_ADDR_ACCUMULATOR, 8'hff, 8'h5e);
    `CBS_CHK(bank, 3'h0)
    wdt_reset;
    rd(`CBS_ADDR_BANK_SELECT, 8'h07, 8'h00);
    @(posedge clk) halt <= 1'b1;
    @(posedge clk) halt <= 1'b0;
    rd(`CBS_ADDR_FLAGS_STATUS, 8'h30, 8'h10);
    wr(`CBS_ADDR_BANK_SELECT, 8'h03);
    wdt_reset;
    rd(`CBS_ADDR_BANK_SELECT, 8'h07, 8'h03);
    wr(`CBS_ADDR_FLAGS_STATUS, 8'hff);
    rd(`CBS_ADDR_FLAGS_STATUS, 8'hff, 8'h1f);
    wr(`CBS_ADDR_FLAGS_STATUS, 8'h00);
    rd(`CBS_ADDR_FLAGS_STATUS, 8'hff, 8'h10);
    @(posedge clk) wto <= 1'b1;
    step(4);
    wto <= 1'b0;
    step(4);
    rd(`CBS_ADDR_FLAGS_STATUS, 8'h30, 8'h30);
    @(posedge clk) wclr <= 1'b1;
    @(posedge clk) wclr <= 1'b0;
    rd(`CBS_ADDR_FLAGS_STATUS, 8'h30, 8'h00);
    for (i = 0; i < 8; i = i + 1) begin
      alu(tab[i][26:24], tab[i][23:16], tab[i][15:8]);
      rd(`CBS_ADDR_FLAGS_STATUS, {4'h0, tab[i][7:4]}, {4'h0, tab[i][3:0]});
    end
    alu(`CBS_OP_ADD, 8'h7f, 8'h01);
    #2 `CBS_CHK(acc, 8'h80)
    alu(`CBS_OP_MOVE, 8'h00, 8'hc3);
    rd(`CBS_ADDR_ACCUMULATOR, 8'hff, 8'hc3);
    wr(`CBS_ADDR_BANK_SELECT, 8'h20);
    wr(`CBS_ADDR_PC_LOW_BYTE, 8'h3c);
    #2 `CBS_CHK({pld, dum, tgt}, {2'b11, 1'b1, 5'h0a, 8'h3c})
    @(posedge clk) #2 `CBS_CHK({pld, dum}, 2'b00)
    wr(`CBS_ADDR_TABLE_PTR_LOW, 8'h34);
    wr(`CBS_ADDR_TABLE_PTR_HI, 8'h12);
    #2 `CBS_CHK(tadr, 16'h1234)
    @(posedge clk) trd <= 1'b1;
    @(posedge clk) trd <= 1'b0;
    rd(`CBS_ADDR_TABLE_RES_HI, 8'hff, 8'h91);
    rd(8'h0b, 8'hff, 8'h00);
    close_out;
  end
endmodule // cbs_core_regs_bench

// >>> test/cbs_core_regs_checker.sv
// Concurrent checks on the core bank and status register ports
`timescale 1ns/1ps
`include "cbs_map.vh"
module cbs_core_regs_checker (
  input wire        CLOCK,
  input wire        NRST,
  input wire        POR_FLAG,
  input wire        WR_EN,
  input wire [7:0]  ADDR,
  input wire        INDIRECT,
  input wire [7:0]  WR_DATA,
  input wire [2:0]  ALU_OP,
  input wire [7:0]  ALU_A,
  input wire [7:0]  ALU_B,
  input wire        WDT_TIMEOUT,
  input wire        WATCHDOG_CLEAR_INSTR,
  input wire        HALT_INSTR,
  input wire [12:0] PC_CURRENT,
  input wire        PC_LOAD,
  input wire [13:0] PC_TARGET,
  input wire        DUMMY_CYCLE,
  input wire [2:0]  DATA_BANK,
  input wire [7:0]  FLAGS_STATUS
);
  wire [8:0] sum = {1'b0, ALU_A} + {1'b0, ALU_B};
  wire pcl_wr = WR_EN && !INDIRECT && ADDR == `CBS_ADDR_PC_LOW_BYTE;
  wire st_wr = WR_EN && !INDIRECT && ADDR == `CBS_ADDR_FLAGS_STATUS;
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);
  // Timeout passes a two-stage sync, so four quiet samples cover it
  sequence wdt_quiet; !WDT_TIMEOUT [*4]; endsequence
  sequence no_sys; !HALT_INSTR && !WATCHDOG_CLEAR_INSTR && !POR_FLAG; endsequence
  pc_jump_a: assert property (pcl_wr |=> PC_LOAD && DUMMY_CYCLE &&
    PC_TARGET[12:0] == {$past(PC_CURRENT[12:8]), $past(WR_DATA)}) else $error("pc jump wrong");
  unused_bits_a: assert property (FLAGS_STATUS[7:6] == 2'b00) else $error("status top bits set");
  direct_bank_a: assert property (!INDIRECT |-> DATA_BANK == 3'h0) else $error("direct bank not 0");
  halt_sets_a: assert property (HALT_INSTR && !POR_FLAG |=> FLAGS_STATUS[4]) else $error("halt no pdf");
  wdt_clear_a: assert property (wdt_quiet ##0 (WATCHDOG_CLEAR_INSTR && !HALT_INSTR && !POR_FLAG)
    |=> FLAGS_STATUS[5:4] == 2'b00) else $error("clear left flags");
  status_ro_a: assert property (wdt_quiet ##0 (st_wr and no_sys) |=> $stable(FLAGS_STATUS[5:4]))
    else $error("status write hit flags");
  zero_flag_a: assert property (ALU_OP == `CBS_OP_LOGIC |=> FLAGS_STATUS[2] == ($past(ALU_B) == 8'h00))
    else $error("zero flag wrong");
  add_carry_a: assert property (ALU_OP == `CBS_OP_ADD |=> FLAGS_STATUS[0] == $past(sum[8]))
    else $error("add carry wrong");
endmodule // cbs_core_regs_checker
bind cbs_core_regs cbs_core_regs_checker chk (.CLOCK, .NRST, .POR_FLAG, .WR_EN, .ADDR, .INDIRECT, .WR_DATA,
  .ALU_OP, .ALU_A, .ALU_B, .WDT_TIMEOUT, .WATCHDOG_CLEAR_INSTR, .HALT_INSTR, .PC_CURRENT, .PC_LOAD,
  .PC_TARGET, .DUMMY_CYCLE, .DATA_BANK, .FLAGS_STATUS);

// >>> test/cbs_cpu_model.sv
// CPU side model: program counter and program memory for table reads
`timescale 1ns/1ps
module cbs_cpu_model #(
  parameter [12:0] PC_INIT = 13'h0a55
) (
  input  wire        clk,
  input  wire        nrst,
  input  wire        pc_load,
  input  wire [13:0] pc_target,
  input  wire [15:0] table_addr,
  output reg  [12:0] pc_current,
  output wire [15:0] table_data
);
  // Word pattern depends on both pointer bytes, so a swapped pair shows
  assign table_data = {table_addr[7:0] ^ 8'ha5, table_addr[15:8]};
  // Jump only where the block asks for one
  always @(posedge clk or negedge nrst) begin
    if (!nrst) pc_current <= PC_INIT;
    else if (pc_load) pc_current <= pc_target[12:0];
  end
endmodule // cbs_cpu_model

// >>> verilog/cbs_core_regs.v
// Core bank selector, accumulator, program counter low, table and status registers
`timescale 1ns/1ps
`include "cbs_map.vh"
// Operation
// - Bank selector bit 5 picks program bank; bits 0..2 pick data bank.
// - Any reset zeroes data bank, except watchdog reset while powered down.
// - Special function registers decode the same in every data bank.
// - Direct data addressing always reaches bank 0.
// - Three-bit data bank codes 000..101 give banks 0..5; others undefined.
// - Program bank 0 covers 0000H-1FFFH, bank 1 covers 2000H-2FFFH.
// - Two-bit variants: codes 00,01,10 give banks 0..2; 11 bank 3 or undefined.
// - Unimplemented bank selector and status bits read as zero.
// - All ALU results land in the accumulator; moves go through it.
// - Writing pc low byte jumps within page and inserts one dummy cycle.
// - Table read fetches at table pointers; high byte into table result high.
// - Software writes never change watchdog timeout or power-down flags.
// - Watchdog timeout flag cleared by power-up, watchdog clear, halt; set by timeout.
// - Power-down flag cleared by power-up or watchdog clear; set by halt.
// - Carry set on add carry or subtract no-borrow; rotates through carry update it.
// - Half carry set on low-nibble carry or no nibble borrow, else cleared.
// - Zero flag set when arithmetic or logic result is zero.
// - Overflow set when carry into top bit differs from carry out.
// - Status is never saved automatically on interrupt or call.
module cbs_core_regs (
  input  wire        CLOCK,
  input  wire        NRST,
  input  wire        WDT_RST_N,
  input  wire        POR_FLAG,
  input  wire        WR_EN,
  input  wire        RD_EN,
  input  wire [7:0]  ADDR,
  input  wire        INDIRECT,
  input  wire [7:0]  WR_DATA,
  output reg  [7:0]  RD_DATA,
  input  wire [2:0]  ALU_OP,
  input  wire [7:0]  ALU_A,
  input  wire [7:0]  ALU_B,
  input  wire        ACC_LOAD,
  input  wire        WDT_TIMEOUT,
  input  wire        WATCHDOG_CLEAR_INSTR,
  input  wire        HALT_INSTR,
  input  wire        TABLE_READ,
  input  wire [15:0] TABLE_DATA,
  output wire [15:0] TABLE_ADDR,
  input  wire        TWO_BIT_BANKS,
  input  wire        FOUR_BANKS,
  input  wire [12:0] PC_CURRENT,
  output reg         PC_LOAD,
  output reg  [13:0] PC_TARGET,
  output reg         DUMMY_CYCLE,
  output wire [2:0]  DATA_BANK,
  output wire        DATA_BANK_UNDEF,
  output wire        PROG_BANK,
  output wire [13:0] PROG_BASE,
  output wire [7:0]  ACCUMULATOR,
  output wire [7:0]  FLAGS_STATUS
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  // Special registers ignore the bank selector entirely
  function sfr_hit;
    input [7:0] a;
    input [7:0] reg_addr;
    begin
      sfr_hit = (a == reg_addr);
    end
  endfunction

  // ****************************************************************
  // Synchronised watchdog reset, power-up and timeout levels
  // ****************************************************************
  reg wdt_rst_s1_q;
  reg wdt_rst_s2_q;
  reg por_s1_q;
  reg por_s2_q;
  reg wdt_to_s1_q;
  reg wdt_to_s2_q;

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      wdt_rst_s1_q <= 1'b1;
      wdt_rst_s2_q <= 1'b1;
      por_s1_q     <= 1'b0;
      por_s2_q     <= 1'b0;
      wdt_to_s1_q  <= 1'b0;
      wdt_to_s2_q  <= 1'b0;
    end else begin
      wdt_rst_s1_q <= WDT_RST_N;
      wdt_rst_s2_q <= wdt_rst_s1_q;
      por_s1_q     <= POR_FLAG;
      por_s2_q     <= por_s1_q;
      wdt_to_s1_q  <= WDT_TIMEOUT;
      wdt_to_s2_q  <= wdt_to_s1_q;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  reg [2:0]  data_bank_q;
  reg        prog_bank_sel_q;
  reg [7:0]  accumulator_q;
  reg [7:0]  table_ptr_low_q;
  reg [7:0]  table_ptr_high_q;
  reg [7:0]  table_result_high_q;
  reg        wdt_timeout_flag_q;
  reg        powerdown_flag_q;
  reg [3:0]  arith_q;
  reg        por_seen_q;

  wire wr_bs   = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_BANK_SELECT);
  wire wr_acc  = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_ACCUMULATOR);
  wire wr_pcl  = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_PC_LOW_BYTE);
  wire wr_table_ptr_low = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_TABLE_PTR_LOW);
  wire wr_table_ptr_high = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_TABLE_PTR_HI);
  wire wr_table_result_high = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_TABLE_RES_HI);
  wire wr_st   = WR_EN & ~INDIRECT & sfr_hit(ADDR, `CBS_ADDR_FLAGS_STATUS);

  // Watchdog reset while powered down keeps the bank; any other resets it
  wire wdt_reset_evt = ~wdt_rst_s2_q;
  wire keep_bank     = wdt_reset_evt & powerdown_flag_q;

  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      data_bank_q     <= 3'h0;
      prog_bank_sel_q <= 1'b0;
    end else if (wdt_reset_evt) begin
      if (!keep_bank) begin
        data_bank_q <= 3'h0;
      end
    end else if (wr_bs) begin
      data_bank_q     <= WR_DATA[2:0];
      prog_bank_sel_q <= WR_DATA[`CBS_BS_PROG_BIT];
    end
  end

  // ****************************************************************
  // ALU flag computation
  // ****************************************************************
  reg [8:0] sum_w;
  reg [4:0] nib_w;
  reg [7:0] res_w;
  reg       c_w;
  reg       ac_w;
  reg       ov_w;
  reg       c_into_msb;
  reg [3:0] arith_d;
  reg       flags_upd;

  always @* begin
    sum_w      = 9'h000;
    nib_w      = 5'h00;
    res_w      = ALU_B;
    c_w        = arith_q[`CBS_ST_CARRY];
    ac_w       = arith_q[`CBS_ST_HALF_CARRY];
    ov_w       = arith_q[`CBS_ST_OVERFLOW];
    c_into_msb = 1'b0;
    flags_upd  = 1'b1;
    case (ALU_OP)
      `CBS_OP_ADD: begin
        sum_w      = {1'b0, ALU_A} + {1'b0, ALU_B};
        nib_w      = {1'b0, ALU_A[3:0]} + {1'b0, ALU_B[3:0]};
        c_into_msb = ALU_A[7] ^ ALU_B[7] ^ sum_w[7];
        res_w      = sum_w[7:0];
        c_w        = sum_w[8];
        ac_w       = nib_w[4];
        ov_w       = c_into_msb ^ sum_w[8];
      end
      `CBS_OP_SUB: begin
        // Subtract as A + ~B + 1, so carry out means no borrow
        sum_w      = {1'b0, ALU_A} + {1'b0, ~ALU_B} + 9'h001;
        nib_w      = {1'b0, ALU_A[3:0]} + {1'b0, ~ALU_B[3:0]} + 5'h01;
        c_into_msb = ALU_A[7] ^ ~ALU_B[7] ^ sum_w[7];
        res_w      = sum_w[7:0];
        c_w        = sum_w[8];
        ac_w       = nib_w[4];
        ov_w       = c_into_msb ^ sum_w[8];
      end
      `CBS_OP_LOGIC: res_w = ALU_B;
      `CBS_OP_RLC: begin
        res_w = {ALU_B[6:0], arith_q[`CBS_ST_CARRY]};
        c_w   = ALU_B[7];
      end
      `CBS_OP_RRC: begin
        res_w = {arith_q[`CBS_ST_CARRY], ALU_B[7:1]};
        c_w   = ALU_B[0];
      end
      default: flags_upd = 1'b0;
    endcase
    arith_d = {ov_w, (res_w == 8'h00), ac_w, c_w};
  end

  // ****************************************************************
  // Accumulator and table registers
  // ****************************************************************
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      accumulator_q       <= 8'h00;
      table_ptr_low_q     <= 8'h00;
      table_ptr_high_q    <= 8'h00;
      table_result_high_q <= 8'h00;
    end else begin
      if (ACC_LOAD) begin
        accumulator_q <= res_w;
      end else if (wr_acc) begin
        accumulator_q <= WR_DATA;
      end
      if (wr_table_ptr_low) begin
        table_ptr_low_q <= WR_DATA;
      end
      if (wr_table_ptr_high) begin
        table_ptr_high_q <= WR_DATA;
      end
      if (TABLE_READ) begin
        table_result_high_q <= TABLE_DATA[15:8];
      end else if (wr_table_result_high) begin
        table_result_high_q <= WR_DATA;
      end
    end
  end

  assign TABLE_ADDR = {table_ptr_high_q, table_ptr_low_q};

  // ****************************************************************
  // Status register
  // ****************************************************************
  // Arithmetic flags are not reset; no storage path to a stack exists
  always @(posedge CLOCK) begin
    if (flags_upd) begin
      arith_q <= arith_d;
    end else if (wr_st) begin
      arith_q <= WR_DATA[3:0];
    end
  end

  // Power-up clears the system flags once, on the first edge that sees the synchronised power-up level
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      por_seen_q         <= 1'b0;
      wdt_timeout_flag_q <= 1'b0;
      powerdown_flag_q   <= 1'b0;
    end else begin
      // Arm only once the synchronised power-up level has arrived
      if (por_s2_q) begin
        por_seen_q <= 1'b1;
      end
      if (por_s2_q && !por_seen_q) begin
        wdt_timeout_flag_q <= 1'b0;
        powerdown_flag_q   <= 1'b0;
      end else begin
        // Timeout wins over a clear in the same cycle
        if (wdt_to_s2_q) begin
          wdt_timeout_flag_q <= 1'b1;
        end else if (WATCHDOG_CLEAR_INSTR || HALT_INSTR) begin
          wdt_timeout_flag_q <= 1'b0;
        end
        if (HALT_INSTR) begin
          powerdown_flag_q <= 1'b1;
        end else if (WATCHDOG_CLEAR_INSTR) begin
          powerdown_flag_q <= 1'b0;
        end
      end
    end
  end

  assign FLAGS_STATUS = {2'b00, wdt_timeout_flag_q, powerdown_flag_q, arith_q};
  assign ACCUMULATOR  = accumulator_q;

  // ****************************************************************
  // Program counter low write
  // ****************************************************************
  always @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      PC_LOAD     <= 1'b0;
      PC_TARGET   <= 14'h0000;
      DUMMY_CYCLE <= 1'b0;
    end else begin
      PC_LOAD     <= wr_pcl;
      DUMMY_CYCLE <= wr_pcl;
      if (wr_pcl) begin
        PC_TARGET <= {prog_bank_sel_q, PC_CURRENT[12:8], WR_DATA};
      end
    end
  end

  // ****************************************************************
  // Bank outputs
  // ****************************************************************
  // Direct accesses ignore the selector
  assign DATA_BANK = INDIRECT ? data_bank_q : 3'h0;
  assign DATA_BANK_UNDEF = TWO_BIT_BANKS ?
                           (data_bank_q[1:0] == 2'b11 && !FOUR_BANKS) :
                           (data_bank_q > `CBS_DATA_BANK_MAX);
  assign PROG_BANK = prog_bank_sel_q;
  assign PROG_BASE = prog_bank_sel_q ? `CBS_PROG_BANK1_LO : 14'h0000;

  // ****************************************************************
  // Read mux
  // ****************************************************************
  always @* begin
    RD_DATA = 8'h00;
    if (RD_EN && !INDIRECT) begin
      case (ADDR)
        `CBS_ADDR_BANK_SELECT:   RD_DATA = {2'b00, prog_bank_sel_q, 2'b00, data_bank_q};
        `CBS_ADDR_ACCUMULATOR:   RD_DATA = accumulator_q;
        `CBS_ADDR_PC_LOW_BYTE:   RD_DATA = PC_CURRENT[7:0];
        `CBS_ADDR_TABLE_PTR_LOW: RD_DATA = table_ptr_low_q;
        `CBS_ADDR_TABLE_RES_HI:  RD_DATA = table_result_high_q;
        `CBS_ADDR_TABLE_PTR_HI:  RD_DATA = table_ptr_high_q;
        `CBS_ADDR_FLAGS_STATUS:  RD_DATA = FLAGS_STATUS;
        default:                 RD_DATA = 8'h00;
      endcase
    end
  end

endmodule // cbs_core_regs

// >>> verilog/cbs_map.vh
// Offsets, field positions, reset values and codes for the core bank and status registers
`ifndef CBS_MAP_VH
`define CBS_MAP_VH
// ****************************************************************
// Register offsets in the special function space
// ****************************************************************
`define CBS_ADDR_BANK_SELECT   8'h04
`define CBS_ADDR_ACCUMULATOR   8'h05
`define CBS_ADDR_PC_LOW_BYTE   8'h06
`define CBS_ADDR_TABLE_PTR_LOW 8'h07
`define CBS_ADDR_TABLE_RES_HI  8'h08
`define CBS_ADDR_TABLE_PTR_HI  8'h09
`define CBS_ADDR_FLAGS_STATUS  8'h0a
`define CBS_SFR_LIMIT          8'h80
// ****************************************************************
// Field positions
// ****************************************************************
`define CBS_BS_PROG_BIT   5
`define CBS_ST_CARRY      0
`define CBS_ST_HALF_CARRY 1
`define CBS_ST_ZERO       2
`define CBS_ST_OVERFLOW   3
`define CBS_ST_POWERDOWN  4
`define CBS_ST_WDT_TO     5
// ****************************************************************
// Masks and reset values
// ****************************************************************
`define CBS_BS_MASK       8'h27
`define CBS_ST_MASK       8'h3f
`define CBS_ST_SW_MASK    8'h0f
`define CBS_BS_RESET      8'h00
`define CBS_DATA_BANK_MAX 3'h5
`define CBS_PROG_BANK0_HI 14'h1fff
`define CBS_PROG_BANK1_LO 14'h2000
`define CBS_PROG_BANK1_HI 14'h2fff
// ****************************************************************
// ALU operation codes
// ****************************************************************
`define CBS_OP_NONE 3'h0
`define CBS_OP_ADD  3'h1
`define CBS_OP_SUB  3'h2
`define CBS_OP_LOGIC 3'h3
`define CBS_OP_RLC  3'h4
`define CBS_OP_RRC  3'h5
`define CBS_OP_MOVE 3'h6
`endif
